// ===== rtl/pspram_pkg.sv
// Package: constants and types shared by both ends of the pipelined SRAM port
package pspram_pkg;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int WORD_W = 36;
    localparam int ADDR_W = 10;
    localparam int BURST_W = 2;
    localparam int PIPE_DEPTH = 2;
    localparam logic MODE_RESET = 1'b1;
    localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;

    typedef enum logic [1:0]
    {
        PSP_IDLE = 2'b00,
        PSP_READ = 2'b01,
        PSP_WRITE = 2'b10
    } psp_op_t;

    // Burst step: interleaved xors the count, linear adds it
    function automatic logic [BURST_W-1:0] psp_burst_addr(input logic [BURST_W-1:0] base,
        input logic [BURST_W-1:0] cnt, input logic interleave);
        psp_burst_addr = interleave ? (base ^ cnt) : BURST_W'(base + cnt);
    endfunction
endpackage

// ===== rtl/pspram_if.sv
// Interface: pins between the SRAM device and its bus master
`timescale 1ns/1ps
interface pspram_if;
    import pspram_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic write_n;
    logic burst_step_or_load;
    logic clock_gate_n;
    logic select_low_first;
    logic select_high_second;
    logic select_low_third;
    logic out_enable_n;
    logic burst_order;
    logic [LANES-1:0] byte_write_mask_n;
    logic [WORD_W-1:0] dq_dev_out;
    logic [WORD_W-1:0] dq_dev_oe_n;
    logic [WORD_W-1:0] dq_mst_out;
    logic [WORD_W-1:0] dq_mst_oe_n;
    logic [WORD_W-1:0] dq_in;
    // Bus level: whoever enables drives, else pulled high
    genvar gi;
    for (gi = 0; gi < WORD_W; gi++)
    begin : g_bus
        assign dq_in[gi] = !dq_dev_oe_n[gi] ? dq_dev_out[gi] :
                           !dq_mst_oe_n[gi] ? dq_mst_out[gi] : 1'b1;
    end
    modport device (input addr, write_n, burst_step_or_load, clock_gate_n, select_low_first,
        select_high_second, select_low_third, out_enable_n, burst_order, byte_write_mask_n,
        dq_in, output dq_dev_out, dq_dev_oe_n);
    modport master (output addr, write_n, burst_step_or_load, clock_gate_n, select_low_first,
        select_high_second, select_low_third, out_enable_n, burst_order, byte_write_mask_n,
        dq_mst_out, dq_mst_oe_n, input dq_in);
endinterface

// ===== rtl/pspram_device.sv
// Device end: pipelined SRAM array with burst counter and lane control
// How it works
// - Write strobe low starts write, gated edges
// - Step high steps the burst counter
// - Step low loads external address
// - Master loads fresh address after deselect
// - Only gated edges capture inputs, except the burst order strap
// - Selected when first low, second high, third low
// - Output enable low lets device drive
// - Output enable high floats lanes
// - Float on write, after deselect, deselected
// - Clock gate high holds all state except the burst order strap
// - Write lanes go from the pins straight into the array
// - Reads drive the earlier addressed word
// - Four bidirectional eight-bit data lanes
// - Parity bit follows its lane's write select
// - Byte selects enable per-lane writes
// - Burst order select, interleaved high
`timescale 1ns/1ps
module pspram_device
    import pspram_pkg::*;
#(
    parameter int DEPTH = 1 << ADDR_W
)
(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    pspram_if.device BUS,
    output logic [1:0] OP_STATE_O
);
    localparam int LW = LANE_W + 1;
    logic [WORD_W-1:0] mem [DEPTH];
    logic en;
    logic selected;
    logic load;
    logic step;
    psp_op_t new_op;
    psp_op_t op1_q, op2_q;
    logic [ADDR_W-1:0] base_q, addr1_q, addr2_q, cur_addr;
    logic [BURST_W-1:0] cnt_q;
    logic burst_op_q;
    logic burst_wr_q;
    logic [LANES-1:0] be1_q, be2_q, be_cur;
    logic [WORD_W-1:0] rd_q;
    logic drive_q;
    logic mode_q;
    logic mode_taken_q;

    assign en = !BUS.clock_gate_n;
    assign selected = !BUS.select_low_first && BUS.select_high_second
                      && !BUS.select_low_third;
    assign load = en && !BUS.burst_step_or_load;
    assign step = en && BUS.burst_step_or_load && burst_op_q;
    assign cur_addr = load ? BUS.addr :
        {base_q[ADDR_W-1:BURST_W],
         psp_burst_addr(base_q[BURST_W-1:0], BURST_W'(cnt_q + 2'h1), mode_q)};
    assign new_op = (load && selected) ? (BUS.write_n ? PSP_READ : PSP_WRITE) :
                    step ? (burst_wr_q ? PSP_WRITE : PSP_READ) : PSP_IDLE;
    assign be_cur = load ? ~BUS.byte_write_mask_n : be1_q;
    assign OP_STATE_O = op2_q;

    // Burst order strap caught after reset release
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            mode_q <= MODE_RESET;
            mode_taken_q <= 1'b0;
        end
        else if (!mode_taken_q)
        begin
            mode_q <= BUS.burst_order;
            mode_taken_q <= 1'b1;
        end
    end

    // Address, burst counter and two-stage control pipe
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            op1_q <= PSP_IDLE;
            op2_q <= PSP_IDLE;
            base_q <= '0;
            addr1_q <= '0;
            addr2_q <= '0;
            cnt_q <= BURST_RESET;
            burst_op_q <= 1'b0;
            burst_wr_q <= 1'b0;
            be1_q <= '0;
            be2_q <= '0;
        end
        else if (en)
        begin
            if (load)
            begin
                base_q <= BUS.addr;
                cnt_q <= BURST_RESET;
                burst_op_q <= selected;
                burst_wr_q <= !BUS.write_n;
            end
            else if (step)
            begin
                cnt_q <= BURST_W'(cnt_q + 2'h1);
            end
            op1_q <= new_op;
            op2_q <= op1_q;
            addr1_q <= cur_addr;
            addr2_q <= addr1_q;
            be1_q <= be_cur;
            be2_q <= be1_q;
        end
    end

    // Array write on data phase and read word staged for output
    genvar gl;
    for (gl = 0; gl < LANES; gl++)
    begin : g_lane
        always_ff @(posedge CLK_I)
        begin
            if (en && op2_q == PSP_WRITE && be2_q[gl])
            begin
                mem[addr2_q][gl*LW +: LW] <= BUS.dq_in[gl*LW +: LW];
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rd_q <= '0;
            drive_q <= 1'b0;
        end
        else if (en)
        begin
            rd_q <= mem[addr1_q];
            drive_q <= (op1_q == PSP_READ);
        end
    end

    assign BUS.dq_dev_out = rd_q;
    assign BUS.dq_dev_oe_n = {WORD_W{!(drive_q && !BUS.out_enable_n)}};
endmodule // pspram_device

// ===== rtl/pspram_master.sv
// Master end: issues single-word reads and writes to the SRAM port
`timescale 1ns/1ps
module pspram_master
    import pspram_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    pspram_if.master BUS,
    input wire logic REQ_VALID_I,
    input wire logic REQ_WRITE_I,
    input wire logic [ADDR_W-1:0] REQ_ADDR_I,
    input wire logic [WORD_W-1:0] REQ_WDATA_I,
    input wire logic [LANES-1:0] REQ_BE_I,
    input wire logic HOLD_I,
    input wire logic BURST_ORDER_I,
    output logic REQ_READY_O,
    output logic RD_VALID_O,
    output logic [WORD_W-1:0] RD_DATA_O
);
    psp_op_t op0_q, op1_q, op2_q;
    logic [WORD_W-1:0] wd0_q, wd1_q;
    logic [WORD_W-1:0] rd_q;
    logic rv_q;
    logic go;

    assign REQ_READY_O = !HOLD_I;
    assign go = REQ_VALID_I && !HOLD_I;
    assign BUS.clock_gate_n = HOLD_I;
    assign BUS.burst_step_or_load = 1'b0;
    assign BUS.select_low_first = !go;
    assign BUS.select_high_second = 1'b1;
    assign BUS.select_low_third = 1'b0;
    assign BUS.write_n = !(go && REQ_WRITE_I);
    assign BUS.addr = REQ_ADDR_I;
    assign BUS.byte_write_mask_n = ~REQ_BE_I;
    assign BUS.burst_order = BURST_ORDER_I;
    assign BUS.out_enable_n = HOLD_I;
    assign BUS.dq_mst_out = wd1_q;
    assign BUS.dq_mst_oe_n = {WORD_W{op1_q != PSP_WRITE}};
    assign RD_VALID_O = rv_q;
    assign RD_DATA_O = rd_q;

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            op0_q <= PSP_IDLE;
            op1_q <= PSP_IDLE;
            op2_q <= PSP_IDLE;
            wd0_q <= '0;
            wd1_q <= '0;
            rd_q <= '0;
            rv_q <= 1'b0;
        end
        else
        begin
            rv_q <= 1'b0;
            if (!HOLD_I)
            begin
                op0_q <= go ? (REQ_WRITE_I ? PSP_WRITE : PSP_READ) : PSP_IDLE;
                op1_q <= op0_q;
                op2_q <= op1_q;
                wd0_q <= REQ_WDATA_I;
                wd1_q <= wd0_q;
                if (op1_q == PSP_READ)
                begin
                    rd_q <= BUS.dq_in;
                    rv_q <= 1'b1;
                end
            end
        end
    end
endmodule // pspram_master

// ===== verification/pspram_port_sva.sv
// Checker: lane direction and pipeline timing on the pins between both ends
`timescale 1ns/1ps
module pspram_port_sva
    import pspram_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic write_n,
    input wire logic burst_step_or_load,
    input wire logic clock_gate_n,
    input wire logic select_low_first,
    input wire logic select_high_second,
    input wire logic select_low_third,
    input wire logic out_enable_n,
    input wire logic [LANES-1:0] byte_write_mask_n,
    input wire logic [WORD_W-1:0] dq_dev_out,
    input wire logic [WORD_W-1:0] dq_dev_oe_n,
    input wire logic [WORD_W-1:0] dq_mst_oe_n
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    wire logic sel = !select_low_first && select_high_second && !select_low_third;
    wire logic go = sel && !burst_step_or_load && !clock_gate_n;
    wire logic wr = go && !write_n;
    wire logic rd = go && write_n;
    a_no_clash:
        assert property ((~dq_dev_oe_n & ~dq_mst_oe_n) == '0) else $error("lane clash");
    a_oe_float:
        assert property (out_enable_n |-> &dq_dev_oe_n) else $error("drive with oe high");
    a_desel_float:
        assert property ((!sel && !clock_gate_n) [*3] |-> &dq_dev_oe_n)
        else $error("drive when deselected");
    a_write_float:
        assert property (wr ##1 !clock_gate_n ##1 !clock_gate_n |-> &dq_dev_oe_n)
        else $error("drive in write data phase");
    a_write_lanes:
        assert property ((wr && byte_write_mask_n == '0) ##1 !clock_gate_n ##1 !clock_gate_n
            |-> dq_mst_oe_n == '0) else $error("write data missing");
    a_read_drive:
        assert property (rd ##1 !clock_gate_n ##1 (!clock_gate_n && !out_enable_n)
            |-> dq_dev_oe_n == '0) else $error("read data missing");
    a_read_mst_off:
        assert property (rd ##1 !clock_gate_n ##1 !clock_gate_n |-> &dq_mst_oe_n)
        else $error("master drives in read");
    a_hold_state:
        assert property (clock_gate_n ##1 $stable(out_enable_n)
            |-> $stable(dq_dev_oe_n) && $stable(dq_dev_out)) else $error("state moved in hold");
endmodule // pspram_port_sva

// ===== verification/pipelined_sram_bus_port_bench.sv
// Testbench: master and device joined, reads checked against a word model
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module pipelined_sram_bus_port_bench;
    import pspram_pkg::*;
    logic CLK_I = 1'b0;
    logic RSTN_I = 1'b0;
    logic vld = 1'b0;
    logic wrt = 1'b0;
    logic hold = 1'b0;
    logic order = 1'b1;
    logic [ADDR_W-1:0] adr = '0;
    logic [WORD_W-1:0] wdat = '0;
    logic [LANES-1:0] be = '0;
    logic rd_valid;
    logic [WORD_W-1:0] rd_data;
    logic [WORD_W-1:0] mem [int];
    logic [WORD_W-1:0] exp_q [$];
    logic [WORD_W-1:0] got_q [$];
    int miscompares = 0;
    int comparisons = 0;
    int i;
    always #12.5 CLK_I = ~CLK_I;
    pspram_if pspram_if_i ();
    pspram_device pspram_device_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .BUS(pspram_if_i.device),
        .OP_STATE_O());
    pspram_master pspram_master_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .BUS(pspram_if_i.master),
        .REQ_VALID_I(vld), .REQ_WRITE_I(wrt), .REQ_ADDR_I(adr), .REQ_WDATA_I(wdat),
        .REQ_BE_I(be), .HOLD_I(hold), .BURST_ORDER_I(order), .REQ_READY_O(),
        .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data));
    pspram_port_sva pspram_port_sva_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
        .write_n(pspram_if_i.write_n), .burst_step_or_load(pspram_if_i.burst_step_or_load),
        .clock_gate_n(pspram_if_i.clock_gate_n), .select_low_first(pspram_if_i.select_low_first),
        .select_high_second(pspram_if_i.select_high_second),
        .select_low_third(pspram_if_i.select_low_third), .out_enable_n(pspram_if_i.out_enable_n),
        .byte_write_mask_n(pspram_if_i.byte_write_mask_n), .dq_dev_out(pspram_if_i.dq_dev_out),
        .dq_dev_oe_n(pspram_if_i.dq_dev_oe_n), .dq_mst_oe_n(pspram_if_i.dq_mst_oe_n));
    always @(negedge CLK_I)
        if (rd_valid === 1'b1) got_q.push_back(rd_data);
    task automatic close_out;
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One request per cycle; the model merges enabled lanes with parity
    task automatic access(input logic w, input int a, input logic [WORD_W-1:0] d,
        input logic [LANES-1:0] m);
        int k;
        @(negedge CLK_I);
        vld = 1'b1;
        wrt = w;
        adr = ADDR_W'(a);
        wdat = d;
        be = m;
        for (k = 0; k < LANES; k++)
            if (w && m[k]) mem[a][9*k+:9] = d[9*k+:9];
        if (!w) exp_q.push_back(mem[a]);
    endtask
    task automatic drain;
        int n;
        logic [WORD_W-1:0] e;
        logic [WORD_W-1:0] g;
        @(negedge CLK_I);
        vld = 1'b0;
        for (n = 0; n < 20 && got_q.size() < exp_q.size(); n++) @(negedge CLK_I);
        `CHK("read count", exp_q.size(), got_q.size())
        if (got_q.size() != exp_q.size()) close_out();
        while (exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            `CHK("read word", e, g)
        end
    endtask
    initial
    begin
        repeat (3) @(posedge CLK_I);
        @(negedge CLK_I) RSTN_I = 1'b1;
        // Full words back to back, then reads back to back
        for (i = 0; i < 4; i++)
            access(1'b1, 1020 + i, 36'h5A5A5A5A5 ^ {4{9'(i)}}, 4'hF);
        for (i = 0; i < 4; i++) access(1'b0, 1020 + i, '0, 4'h0);
        // One lane each, parity bit included, write turning into read
        for (i = 0; i < 4; i++) access(1'b1, 1020 + i, 36'hFFFFFFFFF, 4'(1 << i));
        for (i = 0; i < 4; i++) access(1'b0, 1020 + i, '0, 4'h0);
        drain();
        // Clock gate held with two reads in flight
        access(1'b0, 1021, '0, 4'h0);
        access(1'b0, 1022, '0, 4'h0);
        @(negedge CLK_I);
        vld = 1'b0;
        hold = 1'b1;
        repeat (5) @(negedge CLK_I);
        hold = 1'b0;
        drain();
        // Second reset with linear order; stored words survive
        RSTN_I = 1'b0;
        order = 1'b0;
        repeat (3) @(negedge CLK_I);
        RSTN_I = 1'b1;
        access(1'b0, 1023, '0, 4'h0);
        access(1'b0, 1020, '0, 4'h0);
        drain();
        close_out();
    end
endmodule // pipelined_sram_bus_port_bench
